// >>> lopsr_bank.sv
// lopsr_bank: oscillator path control and synthesizer readback registers
// assumes byte port on clk_sys; staged words and triggers from synthesizer core
`timescale 1ns/1ps
`default_nettype none
module lopsr_bank
    import lopsr_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // async reset, low
    input wire logic reg_wr, // register write strobe
    input wire logic reg_rd, // register read strobe
    input wire logic [LOPSR_AW-1:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // write data
    output logic [7:0] reg_rdata, // read data, held
    output logic reg_ack, // one-cycle answer
    input wire logic mute_req, // general mute request
    input wire logic [1:0] general_silence_depth, // mute depth setting
    input wire logic phase_trig_pin, // general-purpose phase trigger, async
    input wire logic hop_req, // hop request from a staging write elsewhere
    input wire logic [13:0] stage_frac2, // staged secondary fraction
    input wire logic [23:0] stage_frac, // staged fraction
    input wire logic [23:0] stage_phase, // staged phase word
    input wire logic [15:0] stage_intn, // staged integer setpoint
    input wire logic [6:0] stage_rdiv, // staged reference divider
    input wire logic stage_rhalf, // staged reference halving
    input wire logic phase_low_wr, // write to staged phase low byte
    input wire logic rdiv_wr, // write to staged reference divider
    output logic mix_out_en, // mixer output live
    output logic osc_path_output_enable, // oscillator output live
    output logic [1:0] mix_silence_depth, // depth applied to mixer mute
    output logic [1:0] osc_silence_depth, // depth applied to oscillator mute
    output logic depth_limited, // mute depth may be restricted
    output logic external_osc_select, // external input feeds dividers
    output logic [4:0] output_divide_select, // one-hot divider select
    output logic freq_hop, // one-cycle frequency hop
    output logic phase_adjust, // one-cycle phase shift strobe
    output logic [23:0] phase_shift, // amount of phase shift
    output logic rdiv_reset, // one-cycle reference divider reset
    output logic [1:0] modulator_clock_launch_delay // launch delay
);
    typedef struct packed {
        logic [7:0] path;
        logic [4:0] dis;
        logic [7:0] rdata;
        logic ack;
        logic pin_s1;
        logic pin_s2;
        logic pin_d;
        logic hop;
        logic padj;
        logic rrst;
        logic [23:0] shift;
        logic mix_on;
        logic osc_on;
        logic [1:0] mix_dep;
        logic [1:0] osc_dep;
        logic lim;
    } lopsr_st_t;
    lopsr_st_t st, next_st;

    lopsr_shadow_if sh();

    // ==========================================
    // double buffer
    lopsr_dbuf u_dbuf (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sh(sh)
    );

    // true for a legal one-hot divide code
    function automatic logic lopsr_div_ok(input logic [4:0] d);
        return d == LOPSR_DIV1 || d == LOPSR_DIV2 || d == LOPSR_DIV4 || d == LOPSR_DIV8 || d == LOPSR_DIV16;
    endfunction

    logic pin_rise;
    logic hop_now;
    logic div_zero;
    assign pin_rise = st.pin_s2 && !st.pin_d;
    assign hop_now = hop_req && !st.dis[LOPSR_B_HOP_OFF];
    assign div_zero = !lopsr_div_ok(st.path[4:0]);

    // ==========================================
    // staging to buffer: hop loads, bypass follows
    assign sh.frac2 = stage_frac2;
    assign sh.frac = stage_frac;
    assign sh.phase = stage_phase;
    assign sh.intn = stage_intn;
    assign sh.rdiv = stage_rdiv;
    assign sh.rhalf = stage_rhalf;
    assign sh.load = hop_now;
    assign sh.bypass = st.dis[LOPSR_B_DB_BYP];

    // ==========================================
    // register read mux
    function automatic logic [7:0] lopsr_read(input logic [14:0] a, input logic [7:0] p, input logic [4:0] d);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            LOPSR_A_PATH: v = p;
            LOPSR_A_F2L: v = sh.live_frac2[7:0];
            LOPSR_A_F2H: v = {2'b00, sh.live_frac2[13:8]};
            LOPSR_A_FRL: v = sh.live_frac[7:0];
            LOPSR_A_FRM: v = sh.live_frac[15:8];
            LOPSR_A_FRH: v = sh.live_frac[23:16];
            LOPSR_A_PHL: v = sh.live_phase[7:0];
            LOPSR_A_PHM: v = sh.live_phase[15:8];
            LOPSR_A_PHH: v = sh.live_phase[23:16];
            LOPSR_A_INL: v = sh.live_intn[7:0];
            LOPSR_A_INH: v = sh.live_intn[15:8];
            LOPSR_A_RDV: v = {1'b0, sh.live_rdiv};
            LOPSR_A_RH2: v = {7'h00, sh.live_rhalf};
            LOPSR_A_DIS: v = {3'b000, d};
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ==========================================
    // next state
    always_comb begin
        next_st = st;
        next_st.ack = reg_wr || reg_rd;
        if (reg_rd) begin
            next_st.rdata = lopsr_read(reg_addr, st.path, st.dis);
        end
        // only two writable addresses; readback writes fall through
        if (reg_wr && reg_addr == LOPSR_A_PATH) begin
            next_st.path = reg_wdata;
        end
        if (reg_wr && reg_addr == LOPSR_A_DIS) begin
            next_st.dis = reg_wdata[4:0];
        end
        next_st.pin_s1 = phase_trig_pin;
        next_st.pin_s2 = st.pin_s1;
        next_st.pin_d = st.pin_s2;
        next_st.hop = hop_now;
        next_st.padj = (phase_low_wr && !st.dis[LOPSR_B_PH_OFF]) || pin_rise;
        if (next_st.padj) begin
            next_st.shift = sh.live_phase;
        end
        next_st.rrst = rdiv_wr && st.dis[LOPSR_B_DB_BYP];
        // mute when enable clear, mute set, or divide code not a legal one-hot value
        next_st.mix_on = st.path[LOPSR_B_MIX_OE] && !mute_req && !div_zero;
        next_st.osc_on = st.path[LOPSR_B_OSC_OE] && !mute_req && !div_zero;
        next_st.mix_dep = general_silence_depth;
        next_st.osc_dep = general_silence_depth;
        // one muted while the other stays on
        next_st.lim = next_st.mix_on ^ next_st.osc_on;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.path <= LOPSR_R_PATH;
            st.dis <= LOPSR_R_DIS[4:0];
        end else begin
            st <= next_st;
        end
    end

    // ==========================================
    // outputs from flops
    assign reg_rdata = st.rdata;
    assign reg_ack = st.ack;
    assign mix_out_en = st.mix_on;
    assign osc_path_output_enable = st.osc_on;
    assign mix_silence_depth = st.mix_dep;
    assign osc_silence_depth = st.osc_dep;
    assign depth_limited = st.lim;
    assign external_osc_select = st.path[LOPSR_B_EXT];
    assign output_divide_select = st.path[4:0];
    assign freq_hop = st.hop;
    assign phase_adjust = st.padj;
    assign phase_shift = st.shift;
    assign rdiv_reset = st.rrst;
    assign modulator_clock_launch_delay = st.dis[4:3];

    // ==========================================
    // checks
    a_path_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_wr && reg_addr == LOPSR_A_PATH |=> output_divide_select == $past(reg_wdata[4:0]))
        else $error("path write not applied");
    a_mix_mute: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mute_req || !st.path[LOPSR_B_MIX_OE]) |=> !mix_out_en) else $error("mixer not muted");
    a_osc_mute: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st.path[4:0] == 5'h00) |=> !osc_path_output_enable) else $error("osc not muted");
    // flag judged from the settings, not from the registered enables
    a_depth_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st.path[LOPSR_B_MIX_OE] && !st.path[LOPSR_B_OSC_OE] && !mute_req && !div_zero |=> depth_limited)
        else $error("limit flag missing");
    a_ext_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_wr && reg_addr == LOPSR_A_PATH |=> external_osc_select == $past(reg_wdata[5]))
        else $error("external select wrong");
    a_launch_dly: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_wr && reg_addr == LOPSR_A_DIS |=> modulator_clock_launch_delay == $past(reg_wdata[4:3]))
        else $error("launch delay wrong");
    a_hop_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st.dis[LOPSR_B_HOP_OFF] |=> !freq_hop) else $error("hop while off");
    a_rdiv_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rdiv_wr && st.dis[LOPSR_B_DB_BYP] |=> rdiv_reset) else $error("no divider reset");
    a_phase_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
        phase_low_wr && st.dis[LOPSR_B_PH_OFF] && !pin_rise |=> !phase_adjust)
        else $error("phase adjust while off");
    a_ro_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_wr && reg_addr != LOPSR_A_PATH |=> st.path == $past(st.path)) else $error("path changed");
    a_int_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && reg_addr == LOPSR_A_INL |=> reg_rdata == $past(sh.live_intn[7:0]))
        else $error("integer readback wrong");
endmodule // lopsr_bank
`default_nettype wire

// >>> lopsr_bank_tb_top.sv
// lopsr_bank_tb_top: self-checking bench for the path control and readback bank
// assumes lopsr_pkg compiled first; bench drives every bank port at the falling edge
`timescale 1ns/1ps
`default_nettype none
module lopsr_bank_tb_top
    import lopsr_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, mute_req = 1'b0, phase_trig_pin = 1'b0, hop_req = 1'b0;
    logic [14:0] reg_addr = 15'h0000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [1:0] general_silence_depth = 2'h0, mix_silence_depth, osc_silence_depth, modulator_clock_launch_delay;
    logic [13:0] stage_frac2 = 14'h0000;
    logic [23:0] stage_frac = 24'h000000, stage_phase = 24'h000000, phase_shift;
    logic [15:0] stage_intn = 16'h0000;
    logic [6:0] stage_rdiv = 7'h00;
    logic stage_rhalf = 1'b0, phase_low_wr = 1'b0, rdiv_wr = 1'b0;
    logic reg_ack, mix_out_en, osc_path_output_enable, depth_limited, external_osc_select;
    logic freq_hop, phase_adjust, rdiv_reset;
    logic [4:0] output_divide_select;
    int err_total = 0;
    int check_count = 0;
    // ==========================================
    // clock and device under test
    always #4 clk_sys = ~clk_sys;
    lopsr_bank DUT (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .mute_req(mute_req),
        .general_silence_depth(general_silence_depth), .phase_trig_pin(phase_trig_pin), .hop_req(hop_req),
        .stage_frac2(stage_frac2), .stage_frac(stage_frac), .stage_phase(stage_phase), .stage_intn(stage_intn),
        .stage_rdiv(stage_rdiv), .stage_rhalf(stage_rhalf), .phase_low_wr(phase_low_wr), .rdiv_wr(rdiv_wr),
        .mix_out_en(mix_out_en), .osc_path_output_enable(osc_path_output_enable),
        .mix_silence_depth(mix_silence_depth), .osc_silence_depth(osc_silence_depth),
        .depth_limited(depth_limited), .external_osc_select(external_osc_select),
        .output_divide_select(output_divide_select), .freq_hop(freq_hop), .phase_adjust(phase_adjust),
        .phase_shift(phase_shift), .rdiv_reset(rdiv_reset),
        .modulator_clock_launch_delay(modulator_clock_launch_delay));
    // ==========================================
    // compare, bus and closing tasks
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        cyc(1); reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
        cyc(1); reg_wr = 1'b0; chk("write ack", 24'h1, reg_ack);
    endtask
    task automatic rd(input logic [14:0] a, input logic [7:0] e);
        cyc(1); reg_rd = 1'b1; reg_addr = a;
        cyc(1); reg_rd = 1'b0; chk("read ack", 24'h1, reg_ack); chk($sformatf("rdata %h", a), e, reg_rdata);
    endtask
    // walks the twelve contiguous readback bytes, low address first
    task automatic rd_all(input logic [13:0] f2, input logic [23:0] fr, input logic [23:0] ph,
                          input logic [15:0] in, input logic [6:0] rv, input logic rh);
        logic [95:0] v;
        v = {7'h00, rh, 1'b0, rv, in, ph, fr, 2'b00, f2};
        for (int i = 0; i < 12; i++) rd(LOPSR_A_F2L + 15'(i), v[8*i +: 8]);
    endtask
    task automatic pulse(ref logic s);
        cyc(1); s = 1'b1;
        cyc(1); s = 1'b0;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset();
        chk("divide at reset", 24'h02, output_divide_select);
        rd_all(14'h0, 24'h0, 24'h0, 16'h0189, 7'h03, 1'b0);
        rd(LOPSR_A_PATH, 8'h02);
        rd(LOPSR_A_DIS, 8'h00);
        rd(15'h1500, 8'h00);
    endtask
    task automatic t_path();
        logic [4:0] codes [5] = '{LOPSR_DIV1, LOPSR_DIV2, LOPSR_DIV4, LOPSR_DIV8, LOPSR_DIV16};
        foreach (codes[i]) begin
            wr(LOPSR_A_PATH, {3'b111, codes[i]});
            cyc(1);
            chk("divide", 24'(codes[i]), output_divide_select);
            chk("ext select", 24'h1, external_osc_select);
            chk("both live", 24'h3, {mix_out_en, osc_path_output_enable});
            rd(LOPSR_A_PATH, {3'b111, codes[i]});
        end
        wr(LOPSR_A_PATH, 8'hC0);
        cyc(1);
        chk("zero divide mute", 24'h0, {mix_out_en, osc_path_output_enable});
        wr(LOPSR_A_PATH, 8'hC3);
        cyc(1);
        chk("bad code mute", 24'h0, {mix_out_en, osc_path_output_enable});
        wr(LOPSR_A_PATH, 8'h81);
        cyc(1);
        // mixer on, oscillator off, internal source: 3'b100
        chk("mixer only", 24'h4, {mix_out_en, osc_path_output_enable, external_osc_select});
        chk("depth limited", 24'h1, depth_limited);
        wr(LOPSR_A_PATH, 8'hC1);
        cyc(1);
        chk("not limited", 24'h0, depth_limited);
        mute_req = 1'b1;
        general_silence_depth = 2'h2;
        cyc(2);
        chk("mute", 24'h0, {mix_out_en, osc_path_output_enable});
        chk("depth copy", 24'hA, {mix_silence_depth, osc_silence_depth});
        mute_req = 1'b0;
        cyc(2);
        chk("unmute", 24'h3, {mix_out_en, osc_path_output_enable});
    endtask
    task automatic t_hop();
        stage_frac2 = 14'h2A5C; stage_frac = 24'hA1B2C3; stage_phase = 24'h123456;
        stage_intn = 16'h4321; stage_rdiv = 7'h55; stage_rhalf = 1'b1;
        wr(LOPSR_A_INL, 8'hFF); wr(LOPSR_A_RDV, 8'hFF);
        rd_all(14'h0, 24'h0, 24'h0, 16'h0189, 7'h03, 1'b0);
        wr(LOPSR_A_DIS, 8'h04);
        pulse(hop_req);
        chk("hop gated", 24'h0, freq_hop);
        rd_all(14'h0, 24'h0, 24'h0, 16'h0189, 7'h03, 1'b0);
        wr(LOPSR_A_DIS, 8'h00);
        pulse(hop_req);
        chk("hop", 24'h1, freq_hop);
        rd_all(14'h2A5C, 24'hA1B2C3, 24'h123456, 16'h4321, 7'h55, 1'b1);
    endtask
    task automatic t_phase();
        int n;
        pulse(phase_low_wr);
        chk("phase adjust", 24'h1, phase_adjust);
        chk("phase shift", 24'h123456, phase_shift);
        wr(LOPSR_A_DIS, 8'h01);
        pulse(phase_low_wr);
        chk("phase gated", 24'h0, phase_adjust);
        cyc(1); phase_trig_pin = 1'b1;
        n = 0;
        while (phase_adjust !== 1'b1 && n < 8) begin
            cyc(1); n++;
        end
        chk("pin trigger", 24'h1, phase_adjust);
        phase_trig_pin = 1'b0;
    endtask
    task automatic t_disable();
        wr(LOPSR_A_DIS, 8'hFF);
        rd(LOPSR_A_DIS, 8'h1F);
        chk("launch delay", 24'h3, modulator_clock_launch_delay);
        wr(LOPSR_A_DIS, 8'h02);
        stage_frac = 24'h0F0E0D;
        stage_intn = 16'h00AA;
        stage_rdiv = 7'h11;
        cyc(2);
        rd_all(14'h2A5C, 24'h0F0E0D, 24'h123456, 16'h00AA, 7'h11, 1'b1);
        pulse(rdiv_wr);
        chk("rdiv reset", 24'h1, rdiv_reset);
    endtask
    // ==========================================
    // main sequence and watchdog
    initial begin
        cyc(20);
        rst_n = 1'b1;
        cyc(1);
        t_reset();
        t_path();
        t_hop();
        t_phase();
        t_disable();
        close_out();
    end
    initial begin
        #40000;
        err_total++;
        close_out();
    end
endmodule // lopsr_bank_tb_top
`default_nettype wire

// >>> lopsr_dbuf.sv
// lopsr_dbuf: double buffer holding live synthesizer words
// assumes load pulses come from the register bank
`timescale 1ns/1ps
`default_nettype none
module lopsr_dbuf
    import lopsr_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // async reset, low
    lopsr_shadow_if.buffer sh // staged words in, live out
);
    typedef struct packed {
        logic [13:0] f2;
        logic [23:0] fr;
        logic [23:0] ph;
        logic [15:0] in;
        logic [6:0] rd;
        logic rh;
    } lopsr_db_t;
    lopsr_db_t st, next_st;

    // ==========================================
    // transfer on load, or follow staging while bypassed
    always_comb begin
        next_st = st;
        if (sh.load || sh.bypass) begin
            next_st = '{sh.frac2, sh.frac, sh.phase, sh.intn, sh.rdiv, sh.rhalf};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{14'h0000, 24'h000000, 24'h000000, LOPSR_R_INT, LOPSR_R_RDIV, 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign sh.live_frac2 = st.f2;
    assign sh.live_frac = st.fr;
    assign sh.live_phase = st.ph;
    assign sh.live_intn = st.in;
    assign sh.live_rdiv = st.rd;
    assign sh.live_rhalf = st.rh;

    a_load_copies: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sh.load |=> st.fr == $past(sh.frac)) else $error("load did not copy fraction");
endmodule // lopsr_dbuf
`default_nettype wire

// >>> lopsr_pkg.sv
// lopsr_pkg: constants for the oscillator path and synthesizer readback bank
// assumes a byte-wide register port with 15-bit addresses on one clock
`default_nettype none
package lopsr_pkg;
    localparam int LOPSR_AW = 15;
    // ==========================================
    // register offsets
    localparam logic [14:0] LOPSR_A_PATH = 15'h1414;
    localparam logic [14:0] LOPSR_A_F2L = 15'h1541;
    localparam logic [14:0] LOPSR_A_F2H = 15'h1542;
    localparam logic [14:0] LOPSR_A_FRL = 15'h1543;
    localparam logic [14:0] LOPSR_A_FRM = 15'h1544;
    localparam logic [14:0] LOPSR_A_FRH = 15'h1545;
    localparam logic [14:0] LOPSR_A_PHL = 15'h1546;
    localparam logic [14:0] LOPSR_A_PHM = 15'h1547;
    localparam logic [14:0] LOPSR_A_PHH = 15'h1548;
    localparam logic [14:0] LOPSR_A_INL = 15'h1549;
    localparam logic [14:0] LOPSR_A_INH = 15'h154A;
    localparam logic [14:0] LOPSR_A_RDV = 15'h154B;
    localparam logic [14:0] LOPSR_A_RH2 = 15'h154C;
    localparam logic [14:0] LOPSR_A_DIS = 15'h1583;
    // ==========================================
    // field positions
    localparam int LOPSR_B_MIX_OE = 7;
    localparam int LOPSR_B_OSC_OE = 6;
    localparam int LOPSR_B_EXT = 5;
    localparam int LOPSR_B_HOP_OFF = 2;
    localparam int LOPSR_B_DB_BYP = 1;
    localparam int LOPSR_B_PH_OFF = 0;
    // ==========================================
    // reset values
    localparam logic [7:0] LOPSR_R_PATH = 8'h02;
    localparam logic [7:0] LOPSR_R_DIS = 8'h00;
    localparam logic [15:0] LOPSR_R_INT = 16'h0189;
    localparam logic [6:0] LOPSR_R_RDIV = 7'h03;
    // ==========================================
    // divide codes
    localparam logic [4:0] LOPSR_DIV1 = 5'h01;
    localparam logic [4:0] LOPSR_DIV2 = 5'h02;
    localparam logic [4:0] LOPSR_DIV4 = 5'h04;
    localparam logic [4:0] LOPSR_DIV8 = 5'h08;
    localparam logic [4:0] LOPSR_DIV16 = 5'h10;
endpackage
`default_nettype wire

// >>> lopsr_shadow_if.sv
// lopsr_shadow_if: staged and live synthesizer words between bank and buffer
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface lopsr_shadow_if;
    logic [13:0] frac2;
    logic [23:0] frac;
    logic [23:0] phase;
    logic [15:0] intn;
    logic [6:0] rdiv;
    logic rhalf;
    logic load;
    logic bypass;
    logic [13:0] live_frac2;
    logic [23:0] live_frac;
    logic [23:0] live_phase;
    logic [15:0] live_intn;
    logic [6:0] live_rdiv;
    logic live_rhalf;
    modport bank (output frac2, frac, phase, intn, rdiv, rhalf, load, bypass,
                  input live_frac2, live_frac, live_phase, live_intn, live_rdiv, live_rhalf);
    modport buffer (input frac2, frac, phase, intn, rdiv, rhalf, load, bypass,
                    output live_frac2, live_frac, live_phase, live_intn, live_rdiv, live_rhalf);
endinterface
`default_nettype wire
